// *** hdl/cxp_cpu_end.sv ***
// cxp_cpu_end.sv: processor end, runs extended instructions over the bus
// assumes APB master on the user side and a coprocessor on the bus side
`include "cxp_consts.svh"
`default_nettype none
// Function
// - coprocessor drives or samples during data strobe
// - processor floats data lines in memory transfers
// - even template: word 1101, word 1100
// - odd template: byte 1101, two words 1100
// - odd template: coprocessor takes upper byte
// - template fetch always on external bus
// - internal operation: no further bus cycles
// - busy coprocessor asserts hold until done
// - hold suspends processor except refresh, request
// - internal operation still obeys asserted hold
// - to-processor transfer: word cycle status 1110
// - to-processor cycle reuses last template address
// - memory transfers use status 1010 after hold
// - at most sixteen bytes, count from template
// - even start: words, odd count ends byte
// - odd start: byte first, then even words
// - single byte: one byte cycle at start
// - memory data cycles always on external bus
// - coprocessor absent: trap, no template fetch
// - coprocessor watches bus and status lines
// - coprocessor answers only its two-bit id
module cxp_cpu_end (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // shared bus
  cxp_bus_if.cpu           bus,
  // template data supplied by memory model via bench
  input  wire logic [31:0] template_word,
  input  wire logic [15:0] write_data,
  // refresh request, serviced only in the S_HOLD wait, held or not
  input  wire logic        refresh_req
);
  typedef enum logic [6:0] {
    S_IDLE  = 7'b000_0001,
    S_TRAP  = 7'b000_0010,
    S_TMPL  = 7'b000_0100,
    S_HOLD  = 7'b000_1000,
    S_XFER  = 7'b001_0000,
    S_REFR  = 7'b010_0000,
    S_DONE  = 7'b100_0000
  } cxp_cst_t;

  cxp_cst_t    st_r;
  cxp_pkg::cxp_op_t op_r;
  logic [31:0] ctrl_r;
  logic [15:0] taddr_r, daddr_r, cur_adr_r, last_tadr_r;
  logic [15:0] rdata_r;
  logic [4:0]  left_r;          // bytes remaining, up to 16
  logic [1:0]  tidx_r;          // template cycle index
  logic [1:0]  ph_r;            // bus phase within a cycle
  logic        busy_r, trap_r, odd_t_r;

  // high when the current data cycle moves a single byte rather than a word
  function automatic logic cyc_is_byte(input logic [15:0] a,
                                       input logic [4:0] n);
    cyc_is_byte = a[0] | (n == 5'd1);
  endfunction

  // a write takes effect only at the access edge, where pready is high
  wire wr_w = psel && penable && pready && pwrite;
  wire go_w = wr_w && paddr == `CXP_REG_CTRL
              && pwdata[`CXP_CTRL_GO] && !busy_r;
  wire end_w = ph_r == 2'd2;   // last phase of a bus cycle

  //////////////////////////////////////////////////////////////////////////
  // apb register file, single cycle answer
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl_r  <= `CXP_CTRL_RESET;
      taddr_r <= 16'h0000;
      daddr_r <= 16'h0000;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          `CXP_REG_CTRL:   prdata <= ctrl_r;
          `CXP_REG_TADDR:  prdata <= {16'h0000, taddr_r};
          `CXP_REG_DADDR:  prdata <= {16'h0000, daddr_r};
          `CXP_REG_STATUS: prdata <= {29'h0, trap_r, bus.pause_n, busy_r};
          `CXP_REG_RDATA:  prdata <= {16'h0000, rdata_r};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
      if (wr_w) begin
        case (paddr)
          `CXP_REG_CTRL:  ctrl_r  <= {pwdata[31:1], 1'b0}; // go self clears
          `CXP_REG_TADDR: taddr_r <= pwdata[15:0];
          `CXP_REG_DADDR: daddr_r <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer: template fetch, hold, data cycles
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_r <= S_IDLE; busy_r <= 1'b0; trap_r <= 1'b0;
      ph_r <= 2'd0; tidx_r <= 2'd0; left_r <= 5'd0;
      cur_adr_r <= 16'h0000; last_tadr_r <= 16'h0000;
      op_r <= cxp_pkg::CXP_OP_INTERNAL; odd_t_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      case (st_r)
        S_IDLE: if (go_w) begin
          busy_r <= 1'b1;
          if (!pwdata[`CXP_CTRL_PRESENT]) begin
            trap_r <= 1'b1;
            st_r   <= S_DONE;
          end else begin
            trap_r    <= 1'b0;
            cur_adr_r <= taddr_r;
            odd_t_r   <= taddr_r[0];
            tidx_r    <= 2'd0;
            ph_r      <= 2'd0;
            st_r      <= S_TMPL;
          end
        end
        S_TMPL: begin
          ph_r <= end_w ? 2'd0 : ph_r + 2'd1;
          if (end_w) begin
            last_tadr_r <= cur_adr_r;
            cur_adr_r   <= cur_adr_r + (cur_adr_r[0] ? 16'd1 : 16'd2);
            tidx_r      <= tidx_r + 2'd1;
            if (tidx_r == (odd_t_r ? 2'd2 : 2'd1)) begin
              op_r   <= cxp_pkg::cxp_op_t'(template_word[`CXP_TF_OP_HI:
                                                         `CXP_TF_OP_LO]);
              left_r <= {1'b0, template_word[`CXP_TF_CNT_HI:
                                             `CXP_TF_CNT_LO]} + 5'd1;
              st_r   <= S_HOLD;
            end
          end
        end
        S_HOLD: begin
          ph_r <= 2'd0;
          if (refresh_req) st_r <= S_REFR;
          else if (bus.pause_n) begin
            if (op_r == cxp_pkg::CXP_OP_INTERNAL) st_r <= S_DONE;
            else begin
              if (op_r == cxp_pkg::CXP_OP_TO_CPU)
                cur_adr_r <= last_tadr_r;
              else
                cur_adr_r <= daddr_r;
              st_r <= S_XFER;
            end
          end
        end
        S_REFR: begin                  // refresh cycle, then back to wait
          ph_r <= end_w ? 2'd0 : ph_r + 2'd1;
          if (end_w) st_r <= S_HOLD;
        end
        S_XFER: begin
          ph_r <= end_w ? 2'd0 : ph_r + 2'd1;
          if (end_w) begin
            if (op_r == cxp_pkg::CXP_OP_TO_CPU) begin
              rdata_r <= bus.ad_i;
              st_r    <= S_DONE;
            end else begin
              cur_adr_r <= cur_adr_r +
                (cyc_is_byte(cur_adr_r, left_r) ? 16'd1 : 16'd2);
              left_r <= left_r -
                (cyc_is_byte(cur_adr_r, left_r) ? 5'd1 : 5'd2);
              if (left_r <= 5'd2 && !(cur_adr_r[0] && left_r == 5'd2))
                st_r <= S_DONE;
            end
          end
        end
        S_DONE: begin
          busy_r <= 1'b0;
          st_r   <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bus pin drive, all registered
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      bus.adr <= 16'h0000; bus.addr_strobe <= 1'b0;
      bus.data_strobe <= 1'b0; bus.byte_cycle <= 1'b0;
      bus.rd_cycle <= 1'b0; bus.bus_cycle_status <= `CXP_ST_IDLE;
      bus.cpu_ad_o <= 16'h0000; bus.cpu_ad_oe <= 1'b0;
    end else begin
      bus.addr_strobe <= 1'b0;
      bus.data_strobe <= 1'b0;
      bus.cpu_ad_oe   <= 1'b0;
      bus.bus_cycle_status <= `CXP_ST_IDLE;
      if (st_r == S_TMPL || st_r == S_XFER || st_r == S_REFR) begin
        bus.adr          <= cur_adr_r;
        bus.addr_strobe  <= ph_r == 2'd0;
        bus.data_strobe  <= ph_r != 2'd0;
        bus.rd_cycle     <= !(st_r == S_XFER &&
                              op_r == cxp_pkg::CXP_OP_MEM_WR);
        bus.byte_cycle   <= 1'b0;
        if (st_r == S_TMPL) begin
          bus.bus_cycle_status <= tidx_r == 2'd0 ? `CXP_ST_TMPL_1ST
                                                 : `CXP_ST_TMPL_NXT;
          bus.byte_cycle <= cur_adr_r[0] && tidx_r == 2'd0;
        end else if (st_r == S_REFR)
          bus.bus_cycle_status <= `CXP_ST_REFRESH;
        else if (op_r == cxp_pkg::CXP_OP_TO_CPU)
          bus.bus_cycle_status <= `CXP_ST_TO_CPU;
        else begin
          bus.bus_cycle_status <= `CXP_ST_MEM_XFER;
          bus.byte_cycle <= cyc_is_byte(cur_adr_r, left_r);
        end
        // float data lines in memory transfers
        bus.cpu_ad_oe <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** hdl/cxp_consts.svh ***
// cxp_consts.svh: offsets, status codes and counts for the coprocessor port
// assumes inclusion by bare name from design files
`ifndef CXP_CONSTS_SVH
`define CXP_CONSTS_SVH
// bus cycle status codes
`define CXP_ST_IDLE      4'h0
`define CXP_ST_TMPL_1ST  4'hd
`define CXP_ST_TMPL_NXT  4'hc
`define CXP_ST_TO_CPU    4'he
`define CXP_ST_MEM_XFER  4'ha
`define CXP_ST_REFRESH   4'h1
// template fields: id in [31:30], op in [29:28], count-1 in [27:24]
`define CXP_TF_ID_HI     31
`define CXP_TF_ID_LO     30
`define CXP_TF_OP_HI     29
`define CXP_TF_OP_LO     28
`define CXP_TF_CNT_HI    27
`define CXP_TF_CNT_LO    24
`define CXP_MAX_BYTES    16
// apb register byte offsets (controller side)
`define CXP_REG_CTRL     12'h000
`define CXP_REG_TADDR    12'h004
`define CXP_REG_DADDR    12'h008
`define CXP_REG_STATUS   12'h00c
`define CXP_REG_RDATA    12'h010
// ctrl bits
`define CXP_CTRL_GO      0
`define CXP_CTRL_PRESENT 1
`define CXP_CTRL_RESET   32'h0000_0000
// bus timing: data strobe cycles of one bus cycle (strobe and end phases)
`define CXP_STROBE_CYC   2
`endif

// *** hdl/cxp_pkg.sv ***
// cxp_pkg.sv: types used by the processor end of the coprocessor port
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package cxp_pkg;
  // extended operation classes from the template op field
  typedef enum logic [1:0] {
    CXP_OP_INTERNAL = 2'h0,
    CXP_OP_TO_CPU   = 2'h1,
    CXP_OP_MEM_RD   = 2'h2,
    CXP_OP_MEM_WR   = 2'h3
  } cxp_op_t;
endpackage
`default_nettype wire

// *** hdl/cxp_bus_if.sv ***
// cxp_bus_if.sv: shared system bus between processor and coprocessors
// assumes the bench resolves ad wire from the enables
`default_nettype none
interface cxp_bus_if;
  logic [15:0] adr;            // address, valid while addr_strobe
  logic        addr_strobe;    // address valid pulse
  logic        data_strobe;    // data phase, active high here
  logic        byte_cycle;     // byte rather than word cycle
  logic        rd_cycle;       // read (into processor/coprocessor)
  logic [3:0]  bus_cycle_status;
  logic [15:0] cpu_ad_o;       // processor data drive
  logic        cpu_ad_oe;
  logic [15:0] cop_ad_o;       // coprocessor data drive
  logic        cop_ad_oe;
  logic [15:0] mem_ad_o;       // memory (bench) data drive
  logic        mem_ad_oe;
  logic [15:0] ad_i;           // resolved data lines
  logic        pause_n;        // hold, active low, wired-and
  modport cpu (output adr, addr_strobe, data_strobe, byte_cycle, rd_cycle,
               bus_cycle_status, cpu_ad_o, cpu_ad_oe,
               input ad_i, pause_n);
  modport cop (input adr, addr_strobe, data_strobe, byte_cycle, rd_cycle,
               bus_cycle_status, ad_i,
               output cop_ad_o, cop_ad_oe, pause_n);
endinterface
`default_nettype wire

// *** hdl/cxp_cop_end.sv ***
// cxp_cop_end.sv: coprocessor end, watches templates and joins transfers
// assumes a processor end on the bus side, plain user ports otherwise
`include "cxp_consts.svh"
`default_nettype none
module cxp_cop_end #(
  parameter logic [1:0] MY_ID = 2'd0
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // shared bus
  cxp_bus_if.cop           bus,
  // user side
  input  wire logic        op_done,     // earlier operation finished
  input  wire logic [15:0] out_data,    // data to processor or memory
  output logic      [31:0] template_r,  // captured template
  output logic             template_vld,
  output logic      [15:0] in_data,     // data captured from memory
  output logic             in_vld
);
  logic        busy_r, sel_r;
  logic [1:0]  tcnt_r;
  logic        odd_r;
  logic        ds_d_r;          // strobe one cycle ago
  wire         ds_first_w;      // first strobe phase of a bus cycle

  // each bus cycle is sampled once, on its first strobe phase
  assign ds_first_w = bus.data_strobe && !ds_d_r;

  //////////////////////////////////////////////////////////////////////////
  // template capture and hold control
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      template_r <= 32'h0000_0000; template_vld <= 1'b0;
      busy_r <= 1'b0; sel_r <= 1'b0; tcnt_r <= 2'd0; odd_r <= 1'b0;
      bus.pause_n <= 1'b1;
      ds_d_r <= 1'b0;
    end else begin
      ds_d_r <= bus.data_strobe;
      template_vld <= 1'b0;
      if (op_done) busy_r <= 1'b0;
      // sample on the first strobe phase of each cycle
      if (ds_first_w) begin
        if (bus.bus_cycle_status == `CXP_ST_TMPL_1ST) begin
          odd_r <= bus.byte_cycle;
          if (bus.byte_cycle) begin
            template_r[31:24] <= bus.ad_i[7:0];
            tcnt_r <= 2'd1;
          end else begin
            template_r[31:16] <= bus.ad_i;
            tcnt_r <= 2'd2;
          end
        end else if (bus.bus_cycle_status == `CXP_ST_TMPL_NXT) begin
          if (odd_r && tcnt_r == 2'd1) begin
            template_r[23:16] <= bus.ad_i[15:8];
            tcnt_r <= 2'd2;
          end else if (tcnt_r == 2'd2) begin
            template_r[15:0] <= bus.ad_i;
            tcnt_r <= 2'd3;
            // identifier decode
            sel_r <= template_r[`CXP_TF_ID_HI:`CXP_TF_ID_LO] == MY_ID;
            if (template_r[`CXP_TF_ID_HI:`CXP_TF_ID_LO] == MY_ID) begin
              template_vld <= 1'b1;
              if (busy_r && !op_done) bus.pause_n <= 1'b0;
              busy_r <= 1'b1;
            end
          end
        end
      end
      if (!bus.pause_n && op_done) bus.pause_n <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // data phase drive and capture
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      bus.cop_ad_o <= 16'h0000; bus.cop_ad_oe <= 1'b0;
      in_data <= 16'h0000; in_vld <= 1'b0;
    end else begin
      in_vld <= 1'b0;
      bus.cop_ad_oe <= 1'b0;
      if (sel_r && bus.addr_strobe &&
          (bus.bus_cycle_status == `CXP_ST_TO_CPU ||
           (bus.bus_cycle_status == `CXP_ST_MEM_XFER && !bus.rd_cycle))) begin
        bus.cop_ad_o  <= out_data;
        bus.cop_ad_oe <= 1'b1;  // stands in the first strobe phase only
      end
      if (sel_r && ds_first_w && bus.rd_cycle &&
          bus.bus_cycle_status == `CXP_ST_MEM_XFER) begin
        in_data <= bus.ad_i;
        in_vld  <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/cxp_port_checker.sv ***
// cxp_port_checker.sv: assertions on the shared processor/coprocessor bus
// assumes the bench connects the interface signals by name
`include "cxp_consts.svh"
`default_nettype none
module cxp_port_checker (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        resetn,
  // bus lines
  input wire logic [15:0] adr,
  input wire logic        addr_strobe,
  input wire logic        data_strobe,
  input wire logic        byte_cycle,
  input wire logic [3:0]  bus_cycle_status,
  input wire logic        cpu_ad_oe,
  input wire logic        cop_ad_oe,
  input wire logic        pause_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  st;
  logic [15:0] tmpl_adr_r;
  logic [4:0]  mem_cyc_r;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  assign st = bus_cycle_status;
  //////////////////////////////////////////////////////////////////////////
  // address of the latest template cycle
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tmpl_adr_r <= 16'h0000;
    end else if (addr_strobe && st[3:1] == 3'b110) begin
      tmpl_adr_r <= adr;
    end
  end
  // data cycles since the latest template start
  always_ff @(posedge ref_clk) begin
    if (!resetn || (addr_strobe && st == `CXP_ST_TMPL_1ST)) begin
      mem_cyc_r <= 5'h00;
    end else if (addr_strobe && st == `CXP_ST_MEM_XFER) begin
      mem_cyc_r <= mem_cyc_r + 5'h01;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  property p_strobe;
    addr_strobe |=> data_strobe [*2] ##1 !data_strobe;
  endproperty
  property p_float;
    data_strobe && st == `CXP_ST_MEM_XFER |-> !cpu_ad_oe;
  endproperty
  property p_cop_window;
    cop_ad_oe |-> data_strobe;
  endproperty
  property p_even_tmpl;
    addr_strobe && st == `CXP_ST_TMPL_1ST && !adr[0] |-> !byte_cycle ##3
      (addr_strobe && st == `CXP_ST_TMPL_NXT && !byte_cycle &&
       adr == $past(adr, 3) + 16'h0002);
  endproperty
  property p_odd_tmpl;
    addr_strobe && st == `CXP_ST_TMPL_1ST && adr[0] |-> byte_cycle ##3
      (addr_strobe && st == `CXP_ST_TMPL_NXT && !byte_cycle &&
       adr == $past(adr, 3) + 16'h0001) ##3
      (addr_strobe && st == `CXP_ST_TMPL_NXT && !byte_cycle &&
       adr == $past(adr, 3) + 16'h0002);
  endproperty
  property p_hold;
    addr_strobe && !pause_n && !$past(pause_n) |-> st == `CXP_ST_REFRESH;
  endproperty
  property p_to_cpu;
    addr_strobe && st == `CXP_ST_TO_CPU |-> !byte_cycle && adr == tmpl_adr_r;
  endproperty
  property p_mem_word;
    addr_strobe && st == `CXP_ST_MEM_XFER && !byte_cycle |-> !adr[0];
  endproperty
  property p_count;
    mem_cyc_r <= 5'd9;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe shape");
  a_float: assert property (p_float) else $error("cpu drives");
  a_cop_window: assert property (p_cop_window) else $error("cop drive");
  a_even_tmpl: assert property (p_even_tmpl) else $error("even fetch");
  a_odd_tmpl: assert property (p_odd_tmpl) else $error("odd fetch");
  a_hold: assert property (p_hold) else $error("cycle in hold");
  a_to_cpu: assert property (p_to_cpu) else $error("to-cpu cycle");
  a_mem_word: assert property (p_mem_word) else $error("odd word");
  a_count: assert property (p_count) else $error("too many cycles");
  c_to_cpu: cover property (addr_strobe && st == `CXP_ST_TO_CPU);
  c_mem: cover property (addr_strobe && st == `CXP_ST_MEM_XFER && byte_cycle);
  c_hold: cover property (!pause_n ##1 pause_n);
  c_odd: cover property (addr_strobe && st == `CXP_ST_TMPL_1ST && adr[0]);
endmodule
`default_nettype wire

// *** tb/cxp_port_test.sv ***
// cxp_port_test.sv: self-checking bench, processor end facing coprocessor end
// assumes design files and checker are compiled before it
`include "cxp_consts.svh"
`default_nettype none
module coprocessor_instruction_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] template_word = 32'h0000_0000;
  logic [15:0] out_data = 16'hc3a5;
  logic        refresh_req = 1'b0;
  logic        op_done = 1'b1;
  logic        flip = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        template_vld;
  logic [15:0] ta_s;
  logic [15:0] da_s;
  logic [3:0]  c_s;
  logic [1:0]  op_s;
  logic        pres_s;
  logic [31:0] s;
  logic        e;
  int          failures = 0;
  int          samples_checked = 0;
  int          n_tvld = 0;
  int          tv0;
  int          cnt[16] = '{default: 0};
  int          snap[16];
  cxp_bus_if bus ();
  ////////////////////////////////////////////////////////////////////////////
  // memory answers reads; released lines toggle every cycle
  assign bus.mem_ad_oe = bus.data_strobe && bus.rd_cycle &&
                         (bus.bus_cycle_status[3:1] == 3'b110 ||
                          bus.bus_cycle_status == `CXP_ST_MEM_XFER);
  // template bytes in fetch order: first cycle, odd second word, the rest
  assign bus.mem_ad_o =
    bus.bus_cycle_status == `CXP_ST_TMPL_1ST ?
      (bus.byte_cycle ? {8'h00, template_word[31:24]} : template_word[31:16]) :
    (ta_s[0] && bus.adr == ta_s + 16'h0001) ? {template_word[23:16], 8'h00} :
      template_word[15:0];
  assign bus.ad_i = bus.cpu_ad_oe ? bus.cpu_ad_o :
                    bus.cop_ad_oe ? bus.cop_ad_o :
                    bus.mem_ad_oe ? bus.mem_ad_o : {8{flip, ~flip}};
  // clock
  always #5 ref_clk = ~ref_clk;
  // cycle counters per status code
  always @(posedge ref_clk) begin
    flip <= ~flip;
    if (resetn && bus.addr_strobe) cnt[bus.bus_cycle_status]++;
    if (resetn && template_vld) n_tvld++;
  end
  // the two ends and the checker
  cxp_cpu_end cxp_cpu_end_inst (.ref_clk, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .bus(bus.cpu),
    .template_word, .write_data(16'h0000), .refresh_req);
  cxp_cop_end #(.MY_ID(2'd1)) cxp_cop_end_inst (.ref_clk, .resetn,
    .bus(bus.cop), .op_done, .out_data, .template_r(), .template_vld,
    .in_data(), .in_vld());
  cxp_port_checker cxp_port_checker_inst (.ref_clk, .resetn, .adr(bus.adr),
    .addr_strobe(bus.addr_strobe), .data_strobe(bus.data_strobe),
    .byte_cycle(bus.byte_cycle), .bus_cycle_status(bus.bus_cycle_status),
    .cpu_ad_oe(bus.cpu_ad_oe), .cop_ad_oe(bus.cop_ad_oe),
    .pause_n(bus.pause_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      failures++;
      end_of_test();
    end
    s = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll status until the sequencer is idle
  task automatic wait_idle();
    int i;
    i = 0;
    do begin
      apb(1'b0, `CXP_REG_STATUS, 32'h0000_0000);
      i++;
    end while (s[0] !== 1'b0 && i < 100);
    if (i >= 100) begin
      failures++;
      end_of_test();
    end
  endtask
  // program one extended instruction and start it
  task automatic run(input logic [15:0] ta, da, input logic [1:0] id, op,
                     input logic [3:0] c, input logic pres, wt);
    snap = cnt;
    tv0 = n_tvld;
    {ta_s, da_s, c_s, op_s, pres_s} = {ta, da, c, op, pres};
    template_word <= {id, op, c, 24'h12_3456};
    apb(1'b1, `CXP_REG_TADDR, {16'h0000, ta});
    apb(1'b1, `CXP_REG_DADDR, {16'h0000, da});
    apb(1'b1, `CXP_REG_CTRL, {30'h0000_0000, pres, 1'b1});
    if (wt) done_chk(id == 2'd1);
  endtask
  // cycle counts of the finished instruction
  task automatic done_chk(input logic hit);
    wait_idle();
    check("template", cnt[13] + cnt[12] - snap[13] - snap[12],
          pres_s ? 2 + ta_s[0] : 0);
    check("to_cpu", cnt[14] - snap[14], pres_s && op_s == 2'd1);
    check("data", cnt[10] - snap[10], pres_s && op_s[1] ?
          32'((c_s + 5'd2 + da_s[0]) >> 1) : 0);
    check("tvld", n_tvld - tv0, pres_s && hit);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    apb(1'b0, `CXP_REG_CTRL, 32'h0000_0000);
    check("ctrl", s, `CXP_CTRL_RESET);
    apb(1'b0, `CXP_REG_STATUS, 32'h0000_0000);
    check("status", s[2:0], 3'b010);
    apb(1'b0, 12'h020, 32'h0000_0000);
    check("unmapped", {s[30:0], e}, 32'h0000_0001);
    run(16'h0100, 16'h0200, 2'd1, 2'd0, 4'd0, 1'b1, 1'b1);
    run(16'h0111, 16'h0200, 2'd1, 2'd1, 4'd0, 1'b1, 1'b1);
    apb(1'b0, `CXP_REG_RDATA, 32'h0000_0000);
    check("rdata", s, {16'h0000, out_data});
    run(16'h0120, 16'h0200, 2'd1, 2'd2, 4'd4, 1'b1, 1'b1);
    run(16'h0131, 16'h0301, 2'd1, 2'd3, 4'd5, 1'b1, 1'b1);
    run(16'h0140, 16'h0305, 2'd1, 2'd2, 4'd0, 1'b1, 1'b1);
    run(16'h0150, 16'h0311, 2'd1, 2'd3, 4'd15, 1'b1, 1'b1);
    run(16'h0160, 16'h0400, 2'd1, 2'd2, 4'd15, 1'b1, 1'b1);
    op_done <= 1'b0;
    run(16'h0170, 16'h0200, 2'd1, 2'd0, 4'd0, 1'b1, 1'b1);
    run(16'h0180, 16'h0200, 2'd2, 2'd0, 4'd0, 1'b1, 1'b1);
    check("other id hold", s[1], 1'b1);
    run(16'h0190, 16'h0320, 2'd1, 2'd3, 4'd3, 1'b1, 1'b0);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, `CXP_REG_STATUS, 32'h0000_0000);
    check("held", s[1:0], 2'b01);
    refresh_req <= 1'b1;
    repeat (12) @(posedge ref_clk);
    refresh_req <= 1'b0;
    check("held data", cnt[10] - snap[10], 0);
    check("refresh", cnt[1] > snap[1], 1);
    op_done <= 1'b1;
    done_chk(1'b1);
    run(16'h01a0, 16'h0200, 2'd1, 2'd1, 4'd0, 1'b0, 1'b1);
    check("trap", s[2], 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
